// ---- msr_pkg.sv ----
// Purpose: constants for the modem status readback block
// Assumes: byte-wide register port, word addresses 4 bits wide
// Notes:   offsets 4 and 5 hold the two read-only status views
package msr_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [3:0] OFF_LINE_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS_LOW   = 4'h4;
  localparam logic [3:0] OFF_STATUS_HIGH  = 4'h5;

  // line_control fields
  localparam int unsigned CTL_RTS_BIT  = 0;
  localparam int unsigned CTL_DTR_BIT  = 1;
  localparam int unsigned CTL_HDX_BIT  = 2;
  localparam int unsigned CTL_MODE_BIT = 3;
  localparam logic [7:0]  CTL_MASK     = 8'h0F;
  localparam logic [7:0]  CTL_RESET    = 8'h08;

  // modem_line_status_low fields
  localparam int unsigned LOW_CARRIER_BIT = 0;
  localparam int unsigned LOW_CTS_BIT     = 2;
  localparam int unsigned LOW_READY_BIT   = 3;
  localparam int unsigned LOW_HDX_BIT     = 4;
  localparam int unsigned LOW_RTS_BIT     = 5;
  localparam int unsigned LOW_DTR_BIT     = 6;
  localparam int unsigned LOW_RING_BIT    = 7;

  // line_mode_status_high fields
  localparam int unsigned HIGH_MODE_BIT = 0;
  localparam int unsigned HIGH_TEST_BIT = 2;

  // modem input vector positions inside the capture stage
  localparam int unsigned IN_CARRIER = 0;
  localparam int unsigned IN_CTS     = 1;
  localparam int unsigned IN_READY   = 2;
  localparam int unsigned IN_RING    = 3;
  localparam int unsigned IN_TEST    = 4;
  localparam int unsigned IN_W       = 5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage : msr_pkg

// ---- msr_line_capture.sv ----
// Purpose: one register stage for the modem input lines
// Assumes: modem lines already synchronous to clk
// Notes:   clears to all-off under reset so no line reads on early
`timescale 1ns/10ps
module msr_line_capture #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] lines_in,
  output logic      [WIDTH-1:0] lines_q
);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lines_q <= '0;
    end else begin
      lines_q <= lines_in;
    end
  end

endmodule : msr_line_capture

// ---- msr_modem_status.sv ----
// Purpose: modem line status readback with line control register
// Assumes: single clock, inputs synchronous, master never waits
// Notes:   read data valid only in the cycle after the read strobe
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps

// How it works
// - low bit 0 shows carrier detect
// - low bit 1 always reads zero
// - low bit 2 mirrors clear to send
// - low byte reports modem ready
// - low byte shows half-duplex versus full-duplex
// - bit 5 shows rts; transfer waits cts
// - bit 6 shows data terminal ready
// - bit 7 shows ring input
// - ring reported regardless of dtr
// - high bit 0 shows protocol mode
// - mode bit initialises to character-oriented
// - high bit 2 shows modem test
module msr_modem_status
  import msr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              carrier,
  input  wire logic              cts,
  input  wire logic              modem_ready,
  input  wire logic              ring,
  input  wire logic              test_mode,
  output logic                   rts,
  output logic                   dtr,
  output logic                   half_duplex,
  output logic                   char_mode,
  output logic                   tx_enable,
  output logic                   rx_enable
);

  logic [IN_W-1:0]   lines_q;
  logic [DATA_W-1:0] ctl;
  logic [DATA_W-1:0] next_ctl;
  logic [DATA_W-1:0] next_rdata;
  logic              next_tx_enable;
  logic              next_rx_enable;

  wire logic         sel_ctl;
  wire logic         sel_low;
  wire logic         sel_high;
  wire logic         ctl_write;
  wire logic [7:0]   status_low;
  wire logic [7:0]   status_high;
  wire logic [7:0]   read_mux;

  // both status views are built by the same packer so unused bits
  // cannot drift apart between them
  function automatic logic [7:0] pack_status(
    input logic       is_low,
    input logic [IN_W-1:0] lines,
    input logic [7:0] ctl_bits,
    input logic       rts_now,
    input logic       dtr_now
  );
    logic [7:0] b;
    b = BYTE_ZERO;
    if (is_low) begin
      b[LOW_CARRIER_BIT] = lines[IN_CARRIER];
      b[LOW_CTS_BIT]     = lines[IN_CTS];
      b[LOW_READY_BIT]   = lines[IN_READY];
      b[LOW_HDX_BIT]     = ctl_bits[CTL_HDX_BIT];
      b[LOW_RTS_BIT]     = rts_now;
      b[LOW_DTR_BIT]     = dtr_now;
      b[LOW_RING_BIT]    = lines[IN_RING];
    end else begin
      b[HIGH_MODE_BIT]   = ctl_bits[CTL_MODE_BIT];
      b[HIGH_TEST_BIT]   = lines[IN_TEST];
    end
    return b;
  endfunction : pack_status

  msr_line_capture #(
    .WIDTH    (IN_W)
  ) u_capture (
    .clk      (clk),
    .resetn   (resetn),
    .lines_in ({test_mode, ring, modem_ready, cts, carrier}),
    .lines_q  (lines_q)
  );

  // address decode
  assign sel_ctl   = (addr == OFF_LINE_CONTROL);
  assign sel_low   = (addr == OFF_STATUS_LOW);
  assign sel_high  = (addr == OFF_STATUS_HIGH);
  // status offsets take no write path at all
  assign ctl_write = wr && sel_ctl;

  assign status_low  = pack_status(1'b1, lines_q, ctl, rts, dtr);
  assign status_high = pack_status(1'b0, lines_q, ctl, rts, dtr);

  // unmapped addresses read as zero
  assign read_mux = sel_low  ? status_low  :
                    sel_high ? status_high :
                    sel_ctl  ? ctl         : BYTE_ZERO;

  assign next_ctl   = ctl_write ? (wdata & CTL_MASK) : ctl;
  assign next_rdata = rd ? read_mux : BYTE_ZERO;

  // data may move only once the modem has answered rts with cts
  assign next_tx_enable = ctl[CTL_RTS_BIT] && lines_q[IN_CTS];
  // half-duplex interlock: no reception while sending
  assign next_rx_enable = !(ctl[CTL_HDX_BIT] && ctl[CTL_RTS_BIT]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl <= CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= BYTE_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // modem-facing outputs come from flops mirroring the control word;
  // the modem owns draining and disconnect timing after a drop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rts         <= CTL_RESET[CTL_RTS_BIT];
      dtr         <= CTL_RESET[CTL_DTR_BIT];
      half_duplex <= CTL_RESET[CTL_HDX_BIT];
      char_mode   <= CTL_RESET[CTL_MODE_BIT];
    end else begin
      rts         <= next_ctl[CTL_RTS_BIT];
      dtr         <= next_ctl[CTL_DTR_BIT];
      half_duplex <= next_ctl[CTL_HDX_BIT];
      char_mode   <= next_ctl[CTL_MODE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b1;
    end else begin
      tx_enable <= next_tx_enable;
      rx_enable <= next_rx_enable;
    end
  end

  // checks

  property p_carrier_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_CARRIER_BIT] == $past(lines_q[IN_CARRIER]);
  endproperty
  a_carrier_bit: assert property (p_carrier_bit)
    else $error("carrier bit does not match captured carrier");

  property p_low_unused;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> !rdata[1];
  endproperty
  a_low_unused: assert property (p_low_unused)
    else $error("low status bit 1 read nonzero");

  property p_cts_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_CTS_BIT] == $past(lines_q[IN_CTS]);
  endproperty
  a_cts_bit: assert property (p_cts_bit)
    else $error("clear to send rise not visible in status");

  property p_ready_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_READY_BIT] == $past(lines_q[IN_READY]);
  endproperty
  a_ready_bit: assert property (p_ready_bit)
    else $error("modem ready bit wrong");

  property p_hdx_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_HDX_BIT] == half_duplex;
  endproperty
  a_hdx_bit: assert property (p_hdx_bit)
    else $error("half-duplex bit differs from line unit state");

  property p_tx_needs_cts;
    @(posedge clk) disable iff (!resetn)
    tx_enable |-> $past(rts) && $past(lines_q[IN_CTS]);
  endproperty
  a_tx_needs_cts: assert property (p_tx_needs_cts)
    else $error("transfer enabled without rts and cts");

  property p_rts_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_RTS_BIT] == $past(rts);
  endproperty
  a_rts_bit: assert property (p_rts_bit)
    else $error("rts status bit differs from rts output");

  property p_hdx_interlock;
    @(posedge clk) disable iff (!resetn)
    half_duplex && rts |-> ##1 !rx_enable;
  endproperty
  a_hdx_interlock: assert property (p_hdx_interlock)
    else $error("receive enabled while sending half-duplex");

  property p_dtr_bit;
    @(posedge clk) disable iff (!resetn)
    ctl_write |=> dtr == $past(wdata[CTL_DTR_BIT]);
  endproperty
  a_dtr_bit: assert property (p_dtr_bit)
    else $error("dtr did not follow control write");

  property p_ring_free_of_dtr;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low && !dtr |=> rdata[LOW_RING_BIT] == $past(lines_q[IN_RING]);
  endproperty
  a_ring_free_of_dtr: assert property (p_ring_free_of_dtr)
    else $error("ring not reported while dtr off");

  property p_mode_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_high |=> rdata[HIGH_MODE_BIT] == $past(char_mode);
  endproperty
  a_mode_bit: assert property (p_mode_bit)
    else $error("mode bit differs from line unit mode");

  property p_mode_init;
    @(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> char_mode && ctl[CTL_MODE_BIT];
  endproperty
  a_mode_init: assert property (p_mode_init)
    else $error("mode not character-oriented after reset");

  property p_test_bit;
    @(posedge clk) disable iff (!resetn)
    rd && sel_high |=> rdata[HIGH_TEST_BIT] == $past(lines_q[IN_TEST]);
  endproperty
  a_test_bit: assert property (p_test_bit)
    else $error("test mode bit wrong");

  property p_high_unused;
    @(posedge clk) disable iff (!resetn)
    rd && sel_high |=> rdata[7:3] == 5'h00 && !rdata[1];
  endproperty
  a_high_unused: assert property (p_high_unused)
    else $error("unused high status bits read nonzero");

  property p_status_read_only;
    @(posedge clk) disable iff (!resetn)
    wr && (sel_low || sel_high) |=> $stable(ctl) && rts == $past(rts);
  endproperty
  a_status_read_only: assert property (p_status_read_only)
    else $error("write to status view changed state");

  property p_dtr_status;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low |=> rdata[LOW_DTR_BIT] == $past(dtr);
  endproperty
  a_dtr_status: assert property (p_dtr_status)
    else $error("dtr status bit differs from dtr output");

  property p_ring_with_dtr;
    @(posedge clk) disable iff (!resetn)
    rd && sel_low && dtr |=> rdata[LOW_RING_BIT] == $past(lines_q[IN_RING]);
  endproperty
  a_ring_with_dtr: assert property (p_ring_with_dtr)
    else $error("ring not reported while dtr on");

  property p_tx_off_without_rts;
    @(posedge clk) disable iff (!resetn)
    !rts |=> !tx_enable;
  endproperty
  a_tx_off_without_rts: assert property (p_tx_off_without_rts)
    else $error("transfer still enabled after rts dropped");

  property p_rx_full_duplex;
    @(posedge clk) disable iff (!resetn)
    !half_duplex |=> rx_enable;
  endproperty
  a_rx_full_duplex: assert property (p_rx_full_duplex)
    else $error("receive blocked in full-duplex");

  property p_mode_write;
    @(posedge clk) disable iff (!resetn)
    ctl_write |=> char_mode == $past(wdata[CTL_MODE_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode did not follow control write");

  property p_status_keeps_lines;
    @(posedge clk) disable iff (!resetn)
    wr && (sel_low || sel_high) |=> $stable({dtr, half_duplex, char_mode});
  endproperty
  a_status_keeps_lines: assert property (p_status_keeps_lines)
    else $error("write to status view moved a control line");

endmodule : msr_modem_status

// ---- msr_modem_model.sv ----
// Purpose: behavioural local modem facing the status block
// Assumes: control lines synchronous to clk
// Notes:   slow selects a long turn-round so late cts is exercised
`timescale 1ns/10ps
module msr_modem_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic rts,
  input  wire logic dtr,
  input  wire logic half_duplex,
  input  wire logic line_up,
  input  wire logic ring_on,
  input  wire logic test_on,
  input  wire logic slow,
  output logic      carrier,
  output logic      cts,
  output logic      modem_ready,
  output logic      ring,
  output logic      test_mode
);
  logic [3:0] wait_cnt;
  wire  [3:0] turn_delay = slow ? 4'hC : 4'h1;

  // cts follows rts only after keying up or draining queued data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      cts      <= 1'b0;
    end else if (rts != cts) begin
      if (wait_cnt >= turn_delay) begin
        cts      <= rts;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end

  // stays connected until drain ends after dtr drops
  assign modem_ready = line_up & (dtr | cts);
  // half-duplex transmit inhibits reception
  assign carrier     = line_up & ~(half_duplex & rts);
  assign ring        = ring_on;
  assign test_mode   = test_on;
endmodule : msr_modem_model

// ---- msr_modem_status_test.sv ----
// Purpose: self-checking bench for the modem status readback block
// Assumes: control register at 0x0, status views at 0x4 and 0x5
// Notes:   modem lines need two edges to reach the status bytes
`timescale 1ns/10ps
module msr_modem_status_test;
  import msr_pkg::*;
  logic              clk, resetn, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              carrier, cts, modem_ready, ring, test_mode;
  logic              rts, dtr, half_duplex, char_mode, tx_enable, rx_enable;
  logic              line_up, ring_on, test_on, slow;
  int                err_total, total_checks, cycles;

  msr_modem_status i_msr_modem_status (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .carrier(carrier), .cts(cts), .modem_ready(modem_ready), .ring(ring), .test_mode(test_mode),
    .rts(rts), .dtr(dtr), .half_duplex(half_duplex), .char_mode(char_mode), .tx_enable(tx_enable),
    .rx_enable(rx_enable));
  msr_modem_model i_msr_modem_model (.clk(clk), .resetn(resetn), .rts(rts), .dtr(dtr), .half_duplex(half_duplex),
    .line_up(line_up), .ring_on(ring_on), .test_on(test_on), .slow(slow), .carrier(carrier), .cts(cts),
    .modem_ready(modem_ready), .ring(ring), .test_mode(test_mode));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wait_tx(input logic lvl);
    int k;
    k = 0;
    while (tx_enable !== lvl && k < 60) begin
      @(posedge clk);
      k++;
    end
    #1;
    check({7'h00, tx_enable}, {7'h00, lvl});
    idle(3);
  endtask : wait_tx

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // hang guard well above the fewer than one hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] v;
    {wr, rd, addr, wdata, line_up, ring_on, test_on, slow} = '0;
    {err_total, total_checks, cycles} = '0;
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(OFF_STATUS_HIGH, v); check(v, 8'h01);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h00);
    $display("test reset done");
    line_up <= 1'b1;
    wr_reg(OFF_LINE_CONTROL, 8'h0A);
    idle(3);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h49);
    wr_reg(OFF_LINE_CONTROL, 8'h0B);
    wait_tx(1'b1);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h6D);
    wr_reg(OFF_LINE_CONTROL, 8'h0F);
    idle(3);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h7C);
    check({7'h00, rx_enable}, 8'h00);
    check({5'h00, half_duplex, dtr, rts}, 8'h07);
    $display("test handshake done");
    slow <= 1'b1;
    ring_on <= 1'b1;
    wr_reg(OFF_LINE_CONTROL, 8'h08);
    idle(2);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h8D);
    check({5'h00, half_duplex, dtr, rts}, 8'h00);
    wait_tx(1'b0);
    // tx gate drops with rts, but the slow modem keeps cts while draining
    idle(10);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h81);
    ring_on <= 1'b0;
    test_on <= 1'b1;
    wr_reg(OFF_LINE_CONTROL, 8'h00);
    idle(3);
    rd_reg(OFF_STATUS_HIGH, v); check(v, 8'h04);
    check({7'h00, char_mode}, 8'h00);
    $display("test ring and mode done");
    wr_reg(OFF_LINE_CONTROL, 8'h08);
    wr_reg(OFF_STATUS_LOW, 8'hFF);
    wr_reg(OFF_STATUS_HIGH, 8'hFE);
    idle(3);
    rd_reg(OFF_STATUS_LOW, v); check(v, 8'h01);
    rd_reg(OFF_STATUS_HIGH, v); check(v, 8'h05);
    rd_reg(OFF_LINE_CONTROL, v); check(v, 8'h08);
    check({4'h0, char_mode, half_duplex, dtr, rts}, 8'h08);
    rd_reg(4'hF, v); check(v, 8'h00);
    $display("test read-only done");
    give_verdict();
  end
endmodule : msr_modem_status_test
